// *** logic/rgd_pkg.sv ***
// shared constants and types for the receiver gain and demodulator control
package rgd_pkg;

	// clock and timing
	localparam int REF_CLK_MHZ = 200;
	localparam int CAL_TIME_US = 200;
	localparam int CAL_CYCLES = CAL_TIME_US * REF_CLK_MHZ;
	localparam int MIN_WAIT_US = 25;
	localparam int MIN_WAIT_CYCLES = MIN_WAIT_US * REF_CLK_MHZ;

	// field widths
	localparam int IF_BW_W = 2;
	localparam int IF_DIV_W = 9;
	localparam int STRENGTH_W = 7;
	localparam int STRENGTH_MAX = 79;
	localparam int POST_BW_W = 10;
	localparam int FILT_W = 16;
	localparam int OVERSAMPLE = 32;

	// reset values of loop settings
	localparam logic [6:0] RAISE_LEVEL_RST = 7'h1e;
	localparam logic [6:0] REDUCE_LEVEL_RST = 7'h46;
	localparam logic [7:0] SETTLE_COUNT_RST = 8'h0a;

	// demodulator select codes
	localparam logic [1:0] DEMOD_LINEAR = 2'h0;
	localparam logic [1:0] DEMOD_CORREL = 2'h1;

	// offset clock divider codes: 4, 8, 16
	localparam logic [1:0] OFS_DIV4 = 2'h0;
	localparam logic [1:0] OFS_DIV8 = 2'h1;
	localparam logic [1:0] OFS_DIV16 = 2'h2;

	// front amp gain field codes (gain 30, 10, 3)
	localparam logic [1:0] FA_GAIN30 = 2'h3;
	localparam logic [1:0] FA_GAIN10 = 2'h2;
	localparam logic [1:0] FA_GAIN3 = 2'h1;

	// gain flag encodings
	localparam logic [1:0] FA_HIGH = 2'h3;
	localparam logic [1:0] FA_MED = 2'h2;
	localparam logic [1:0] FA_LOW = 2'h1;
	localparam logic [1:0] FA_XLOW = 2'h0;
	localparam logic [1:0] IF_HIGH = 2'h2;
	localparam logic [1:0] IF_MED = 2'h1;
	localparam logic [1:0] IF_LOW = 2'h0;

	// gain ladder index: 0 highest gain ... 5 lowest
	localparam logic [2:0] STEP_TOP = 3'h0;
	localparam logic [2:0] STEP_BOTTOM = 3'h5;

	// calibration sequencer states, gray along idle-run-done
	typedef enum logic [1:0] {
		RGD_CAL_IDLE = 2'b00,
		RGD_CAL_RUN = 2'b01,
		RGD_CAL_DONE = 2'b11
	} rgd_cal_e;

endpackage

// *** logic/rgd_if.sv ***
// carrier between the main block and the clock recovery module
`timescale 1ns/1ps
interface rgd_cdr_if;
	logic ovs_tick;
	logic bit_in;
	logic bit_out;
	logic bit_valid;
	modport ctrl (output ovs_tick, output bit_in, input bit_out,
		input bit_valid);
	modport cdr (input ovs_tick, input bit_in, output bit_out,
		output bit_valid);
endinterface // rgd_cdr_if

// *** logic/rgd_cdr.sv ***
// oversampled clock recovery pll for the sliced bit stream
`timescale 1ns/1ps
module rgd_cdr
	import rgd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	rgd_cdr_if.cdr link
);

	logic [4:0] phase_q;
	logic prev_q;
	logic bit_q;
	logic valid_q;

	////////////////////////////////////////////////////////////////////
	// phase counter nudged on each edge; a nudge of one tick per edge
	// covers a few percent of rate error at 32x oversampling
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= 5'h00;
			prev_q <= 1'b0;
		end else if (clk_en && link.ovs_tick) begin
			prev_q <= link.bit_in;
			if (link.bit_in != prev_q) begin
				if (phase_q < 5'h10)
					phase_q <= phase_q + 5'h02; // late edge: speed up
				else
					phase_q <= phase_q; // early edge: hold back
			end else begin
				phase_q <= phase_q + 5'h01;
			end
		end
	end

	// sample at mid bit, which is phase 15 after the edge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_q <= 1'b0;
			valid_q <= 1'b0;
		end else if (clk_en) begin
			valid_q <= 1'b0;
			if (link.ovs_tick && phase_q == 5'h0f) begin
				bit_q <= link.bit_in;
				valid_q <= 1'b1;
			end
		end
	end

	assign link.bit_out = bit_q;
	assign link.bit_valid = valid_q;

endmodule // rgd_cdr

// *** logic/rgd_top.sv ***
// receiver gain loop, if filter calibration and demodulator control
`timescale 1ns/1ps

// What this block does
// - two-bit field selects if filter bandwidth, 100 to 200 kHz
// - calibration start runs filter calibration alone, done after 200 us
// - with gain loop off host sets if gain; on, device sets it
// - receiver mode from amp mode bit, amp gain and mixer linearity
// - seven-bit, 80-level strength code feeds readback and gain loop
// - above upper level step gain down, below lower level step up
// - levels and settle count programmable, defaults 30, 70, 10
// - offset clock is crystal divided by 4, 8 or 16
// - gain loop on after reset; host can switch it off
// - after each gain change wait settle count times sequencer divider
// - readback gives strength code and amp and if gain flags
// - amp flags 11,10,01,00; if flags 10,01,00
// - two-bit select picks correlator or linear demodulator
// - correlator compares plus and minus deviation correlator levels
// - second-order low-pass after discriminator, ten-bit bandwidth
// - correlator slicer threshold fixed at zero
// - recovery pll resamples at 32 times the data rate
// - select code 01 enables the correlator demodulator
// - select code 00 enables the linear demodulator
module rgd_top
	import rgd_pkg::*;
#(
	parameter int CAL_CYCLES_P = CAL_CYCLES,
	parameter int STRENGTH_W_P = STRENGTH_W
)(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [IF_BW_W-1:0] if_bw_sel,
	input wire logic [IF_DIV_W-1:0] if_div,
	input wire logic cal_start,
	output logic cal_busy,
	output logic cal_done,
	output logic [IF_BW_W-1:0] if_bw_applied,
	input wire logic gain_loop_off,
	input wire logic [1:0] manual_if_gain,
	input wire logic front_amp_mode_bit,
	input wire logic [1:0] front_amp_gain_field,
	input wire logic mixer_linear_bit,
	output logic front_amp_mode_out,
	output logic mixer_linear_out,
	input wire logic [6:0] gain_raise_level,
	input wire logic [6:0] gain_reduce_level,
	input wire logic [7:0] gain_settle_count,
	input wire logic [7:0] sequencer_clock_divider,
	input wire logic [1:0] offset_clock_divider,
	output logic offset_clk,
	input wire logic [STRENGTH_W_P-1:0] strength_in,
	output logic [STRENGTH_W_P-1:0] strength_code_bits,
	output logic [1:0] front_amp_gain_flags,
	output logic [1:0] if_gain_flags,
	input wire logic [1:0] demod_sel,
	input wire logic [POST_BW_W-1:0] post_bw,
	input wire logic signed [FILT_W-1:0] corr_plus_level,
	input wire logic signed [FILT_W-1:0] corr_minus_level,
	input wire logic signed [FILT_W-1:0] linear_disc,
	input wire logic demod_tick,
	input wire logic [15:0] recovery_oversample_clock,
	output logic rx_bit,
	output logic rx_bit_valid,
	output logic correlator_on
);

	// clk_en low holds every register; pure decodes still follow inputs

	// ladder index to flags; used for readback and for output gain
	function automatic logic [3:0] step_flags(input logic [2:0] s);
		case (s)
			3'h0: step_flags = {FA_HIGH, IF_HIGH};
			3'h1: step_flags = {FA_MED, IF_HIGH};
			3'h2: step_flags = {FA_MED, IF_MED};
			3'h3: step_flags = {FA_MED, IF_LOW};
			3'h4: step_flags = {FA_LOW, IF_LOW};
			default: step_flags = {FA_XLOW, IF_LOW};
		endcase
	endfunction

	// manual front amp code to flag encoding
	function automatic logic [1:0] amp_flag(input logic [1:0] g);
		case (g)
			FA_GAIN30: amp_flag = FA_HIGH;
			FA_GAIN10: amp_flag = FA_MED;
			FA_GAIN3: amp_flag = FA_LOW;
			default: amp_flag = FA_XLOW;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// if filter calibration sequencer

	rgd_cal_e cal_state_q;
	logic [31:0] cal_cnt_q;
	logic [IF_DIV_W-1:0] cal_div_q;

	// the divider is captured at start; the host must not touch the
	// device while running, so no retrigger is honoured
	// a start from done is honoured too, so a later recalibration
	// works, though one run after power-up is the normal use
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cal_state_q <= RGD_CAL_IDLE;
			cal_cnt_q <= 32'h0;
			cal_div_q <= '0;
		end else if (clk_en) begin
			case (cal_state_q)
				RGD_CAL_IDLE, RGD_CAL_DONE: begin
					if (cal_start) begin
						cal_state_q <= RGD_CAL_RUN;
						cal_cnt_q <= 32'h0;
						cal_div_q <= if_div;
					end
				end
				RGD_CAL_RUN: begin
					if (cal_cnt_q == 32'(CAL_CYCLES_P - 1))
						cal_state_q <= RGD_CAL_DONE;
					else
						cal_cnt_q <= cal_cnt_q + 32'h1;
				end
				default: cal_state_q <= RGD_CAL_IDLE;
			endcase
		end
	end

	// flags decoded from state so they move in the same cycle as it
	assign cal_busy = (cal_state_q == RGD_CAL_RUN);
	assign cal_done = (cal_state_q == RGD_CAL_DONE);

	// bandwidth field applied to the filter when not calibrating
	// a change asked for during calibration waits until it ends
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			if_bw_applied <= '0;
		else if (clk_en && !cal_busy)
			if_bw_applied <= if_bw_sel;
	end

	////////////////////////////////////////////////////////////////////
	// offset correction clock divider

	logic [3:0] ofs_cnt_q;
	logic [3:0] ofs_half;

	// half period minus one; codes above 2 fall back to divide by 16
	always_comb begin
		case (offset_clock_divider)
			OFS_DIV4: ofs_half = 4'h1;
			OFS_DIV8: ofs_half = 4'h3;
			default: ofs_half = 4'h7;
		endcase
	end

	// toggles every half period, so output is crystal over 4, 8, 16
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ofs_cnt_q <= 4'h0;
			offset_clk <= 1'b0;
		end else if (clk_en) begin
			if (ofs_cnt_q >= ofs_half) begin
				ofs_cnt_q <= 4'h0;
				offset_clk <= ~offset_clk;
			end else begin
				ofs_cnt_q <= ofs_cnt_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// gain control loop

	// ladder index 0 is the most gain and 5 the least; one rung per
	// step, so a large jump costs one settle wait for every rung
	logic [2:0] step_q;
	logic [15:0] wait_q;
	logic settling;
	logic [15:0] wait_load;
	logic [3:0] ladder_flags;

	// settle wait in crystal periods; host keeps it at 25 us or more;
	// both factors are 8 bits, so the 16-bit product never wraps
	assign wait_load = 16'(gain_settle_count)
		* 16'(sequencer_clock_divider);
	assign settling = (wait_q != 16'h0);

	// one decode of the rung feeds both flag pairs
	assign ladder_flags = step_flags(step_q);

	// strength code straight into the loop, so no lag versus readback
	// switching the loop off drops any pending wait; the host owns gain
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			step_q <= STEP_TOP;
			wait_q <= 16'h0;
		end else if (clk_en) begin
			if (gain_loop_off) begin
				wait_q <= 16'h0;
			end else if (settling) begin
				wait_q <= wait_q - 16'h1;
			end else if (7'(strength_in) > gain_reduce_level) begin
				if (step_q != STEP_BOTTOM) begin
					step_q <= step_q + 3'h1;
					wait_q <= wait_load;
				end
			end else if (7'(strength_in) < gain_raise_level) begin
				if (step_q != STEP_TOP) begin
					step_q <= step_q - 3'h1;
					wait_q <= wait_load;
				end
			end
		end
	end

	// gain flags: loop picks both, or host picks them when loop is off
	// registered so readback and the front end always see one pair
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			front_amp_gain_flags <= FA_HIGH;
			if_gain_flags <= IF_HIGH;
		end else if (clk_en) begin
			if (gain_loop_off) begin
				front_amp_gain_flags <= amp_flag(front_amp_gain_field);
				if_gain_flags <= manual_if_gain;
			end else begin
				front_amp_gain_flags <= ladder_flags[3:2];
				if_gain_flags <= ladder_flags[1:0];
			end
		end
	end

	// receiver mode bits and strength readback
	// codes above 79 cannot come from an 80-level converter, so clamp
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			front_amp_mode_out <= 1'b0;
			mixer_linear_out <= 1'b0;
			strength_code_bits <= '0;
		end else if (clk_en) begin
			front_amp_mode_out <= front_amp_mode_bit;
			mixer_linear_out <= mixer_linear_bit;
			if (7'(strength_in) > 7'(STRENGTH_MAX))
				strength_code_bits <= STRENGTH_W_P'(STRENGTH_MAX);
			else
				strength_code_bits <= strength_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// demodulator, post filter and slicer

	// disc is the discriminator word, k the filter coefficient
	logic signed [FILT_W-1:0] disc;
	logic signed [FILT_W+9:0] s1_q;
	logic signed [FILT_W+9:0] s2_q;
	logic signed [FILT_W+9:0] k;
	logic signed [FILT_W-1:0] y1;
	logic signed [FILT_W-1:0] y2;
	logic signed [FILT_W-1:0] avg_q;
	logic slice_q;

	assign correlator_on = (demod_sel == DEMOD_CORREL);

	// correlator difference or linear discriminator
	always_comb begin
		if (demod_sel == DEMOD_CORREL)
			disc = corr_plus_level - corr_minus_level;
		else
			disc = linear_disc;
	end

	assign k = $signed({{FILT_W{1'b0}}, post_bw});
	assign y1 = s1_q[FILT_W+9:10];
	assign y2 = s2_q[FILT_W+9:10];

	// two cascaded one-pole sections give second order; states keep
	// ten fraction bits so narrow bandwidths do not stall on rounding
	// the code stays below 1024, so each section gains at most one per
	// tick and cannot ring
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else if (clk_en && demod_tick) begin
			s1_q <= s1_q + (FILT_W+10)'(k * (disc - y1));
			s2_q <= s2_q + (FILT_W+10)'(k * (y1 - y2));
		end
	end

	// slow average for the linear slicer; correlator uses zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			avg_q <= '0;
			slice_q <= 1'b0;
		end else if (clk_en && demod_tick) begin
			avg_q <= avg_q + ((y2 - avg_q) >>> 6);
			if (demod_sel == DEMOD_CORREL)
				slice_q <= (y2 > 0);
			else
				slice_q <= (y2 > avg_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// oversample tick and clock recovery

	logic [15:0] ovs_cnt_q;
	logic ovs_tick;
	rgd_cdr_if cdr_link();

	// tick period set by host to give 32 ticks per bit
	// a period lowered below the count restarts it at the next edge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			ovs_cnt_q <= 16'h0;
		else if (clk_en) begin
			if (ovs_cnt_q >= recovery_oversample_clock)
				ovs_cnt_q <= 16'h0;
			else
				ovs_cnt_q <= ovs_cnt_q + 16'h1;
		end
	end

	assign ovs_tick = (ovs_cnt_q == 16'h0);
	assign cdr_link.ovs_tick = ovs_tick;
	assign cdr_link.bit_in = slice_q;

	// recovery sees the sliced stream and the oversample tick
	rgd_cdr u_cdr (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.link(cdr_link.cdr)
	);

	// recovered bit and its one-cycle strobe leave without more delay
	assign rx_bit = cdr_link.bit_out;
	assign rx_bit_valid = cdr_link.bit_valid;

endmodule // rgd_top

// *** bench/rgd_props.sv ***
// assertion checker for the receiver gain and demodulator control
`timescale 1ns/1ps
module rgd_props
	import rgd_pkg::*;
#(
	parameter int CAL_CYCLES_P = CAL_CYCLES,
	parameter int STRENGTH_W_P = STRENGTH_W
)(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic cal_start,
	input wire logic cal_busy,
	input wire logic cal_done,
	input wire logic [IF_BW_W-1:0] if_bw_applied,
	input wire logic gain_loop_off,
	input wire logic front_amp_mode_bit,
	input wire logic mixer_linear_bit,
	input wire logic front_amp_mode_out,
	input wire logic mixer_linear_out,
	input wire logic [6:0] gain_raise_level,
	input wire logic [6:0] gain_reduce_level,
	input wire logic [7:0] gain_settle_count,
	input wire logic [7:0] sequencer_clock_divider,
	input wire logic [STRENGTH_W_P-1:0] strength_in,
	input wire logic [STRENGTH_W_P-1:0] strength_code_bits,
	input wire logic [1:0] front_amp_gain_flags,
	input wire logic [1:0] if_gain_flags,
	input wire logic [1:0] demod_sel,
	input wire logic correlator_on,
	input wire logic rx_bit_valid
);
	logic [15:0] busy_q;
	logic [15:0] gap_q;
	logic [15:0] wait_c;
	logic [3:0] flags;
	logic [3:0] flags_q;
	logic in_band;
	logic at_top;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	assign flags = {front_amp_gain_flags, if_gain_flags};
	assign wait_c = gain_settle_count * sequencer_clock_divider;
	assign in_band = strength_in >= gain_raise_level
		&& strength_in <= gain_reduce_level;
	assign at_top = flags == 4'he && strength_in < gain_raise_level;
	////////////////////////////////////////////////////////////////////////
	// busy length, and cycles since the gain pair last moved (saturating)
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 16'h0;
			gap_q <= 16'h0;
			flags_q <= 4'he;
		end else begin
			busy_q <= cal_busy ? busy_q + 16'h1 : 16'h0;
			flags_q <= flags;
			if (flags != flags_q) begin
				gap_q <= 16'h0;
			end else if (gap_q != 16'hffff) begin
				gap_q <= gap_q + 16'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_cal_start_busy: assert property (clk_en && cal_start && !cal_busy
		|=> cal_busy) else $error("calibration did not start");
	a_cal_run_len: assert property ($fell(cal_busy)
		|-> busy_q == CAL_CYCLES_P && cal_done)
		else $error("calibration length wrong");
	a_bw_held: assert property (cal_busy && $past(cal_busy)
		|-> $stable(if_bw_applied)) else $error("bandwidth moved in cal");
	a_demod_decode: assert property (
		correlator_on == (demod_sel == DEMOD_CORREL))
		else $error("demodulator select decode wrong");
	a_code_clamp: assert property ($past(reset_n) && $past(clk_en)
		|-> int'(strength_code_bits) == ((int'($past(strength_in)) >
		STRENGTH_MAX) ? STRENGTH_MAX : int'($past(strength_in))))
		else $error("strength code not clamped copy");
	a_mode_copy: assert property ($past(reset_n) && $past(clk_en)
		|-> front_amp_mode_out == $past(front_amp_mode_bit)
		&& mixer_linear_out == $past(mixer_linear_bit))
		else $error("mode bits not copied");
	a_pair_legal: assert property (!gain_loop_off
		&& !$past(gain_loop_off) && !$past(gain_loop_off, 2)
		|-> if_gain_flags != 2'h3
		&& (front_amp_gain_flags != FA_HIGH || if_gain_flags == IF_HIGH)
		&& (front_amp_gain_flags > FA_LOW || if_gain_flags == IF_LOW))
		else $error("gain pair off the ladder");
	a_band_hold: assert property ((in_band && !gain_loop_off)[*3]
		|-> $stable(flags)) else $error("gain moved inside band");
	a_settle_gap: assert property (flags != flags_q
		&& !gain_loop_off && !$past(gain_loop_off)
		|-> int'(gap_q) + 1 >= int'(wait_c))
		else $error("gain stepped during settle wait");
	a_top_hold: assert property ((at_top && !gain_loop_off)[*2]
		|=> flags == 4'he) else $error("gain left top step");
	a_valid_pulse: assert property (rx_bit_valid && clk_en
		|=> !rx_bit_valid) else $error("bit valid longer than one cycle");
	c_cal_end: cover property ($fell(cal_busy));
	c_bottom: cover property (flags == 4'h0 && !gain_loop_off);
	c_bit: cover property (correlator_on && rx_bit_valid);
endmodule // rgd_props

bind rgd_top rgd_props #(
	.CAL_CYCLES_P(CAL_CYCLES_P),
	.STRENGTH_W_P(STRENGTH_W_P)
) props_u (.ref_clk, .reset_n, .clk_en, .cal_start, .cal_busy, .cal_done,
	.if_bw_applied, .gain_loop_off, .front_amp_mode_bit, .mixer_linear_bit,
	.front_amp_mode_out, .mixer_linear_out, .gain_raise_level,
	.gain_reduce_level, .gain_settle_count, .sequencer_clock_divider,
	.strength_in, .strength_code_bits, .front_amp_gain_flags,
	.if_gain_flags, .demod_sel, .correlator_on, .rx_bit_valid);

// *** bench/rgd_rf_model.sv ***
// far side model: front end level, correlators and demodulator strobe
`timescale 1ns/1ps
module rgd_rf_model
	import rgd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] rf_level,
	input wire logic [1:0] amp_flags,
	input wire logic [1:0] if_flags,
	input wire logic tx_bit,
	output logic [6:0] strength,
	output logic signed [FILT_W-1:0] plus_lvl,
	output logic signed [FILT_W-1:0] minus_lvl,
	output logic signed [FILT_W-1:0] disc,
	output logic tick
);
	int lvl;
	logic signed [FILT_W-1:0] wob;
	// code drop of each gain pair; less gain gives a lower code
	always_comb begin
		case ({amp_flags, if_flags})
			4'he: lvl = int'(rf_level);
			4'ha: lvl = int'(rf_level) - 24;
			4'h9: lvl = int'(rf_level) - 45;
			4'h8: lvl = int'(rf_level) - 63;
			4'h4: lvl = int'(rf_level) - 90;
			default: lvl = int'(rf_level) - 105;
		endcase
	end
	// converter lags one cycle; ripple keeps levels from sitting still
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			strength <= 7'h0;
			tick <= 1'b0;
			wob <= 16'sh0;
		end else begin
			strength <= 7'((lvl < 0) ? 0 : ((lvl > 127) ? 127 : lvl));
			tick <= ~tick;
			wob <= wob ^ 16'sh25;
		end
	end
	// plus correlator wins for a one, minus for a zero
	assign plus_lvl = (tx_bit ? 16'sh3e8 : -16'sh3e8) + wob;
	assign minus_lvl = (tx_bit ? -16'sh3e8 : 16'sh3e8) - wob;
	// no carrier offset here, so frequency correction stays off
	assign disc = tx_bit ? 16'sh320 : -16'sh320;
endmodule // rgd_rf_model

// *** bench/tb.sv ***
// self-checking bench for the receiver gain and demodulator control
`timescale 1ns/1ps
module tb;
	import rgd_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cal_start, cal_busy, cal_done, gain_loop_off, front_amp_mode_bit;
	logic mixer_linear_bit, front_amp_mode_out, mixer_linear_out, offset_clk;
	logic demod_tick, rx_bit, rx_bit_valid, correlator_on, tx_bit, look;
	logic [1:0] if_bw_sel, if_bw_applied, manual_if_gain, front_amp_gain_field;
	logic [1:0] offset_clock_divider, front_amp_gain_flags, if_gain_flags;
	logic [1:0] demod_sel;
	logic clk_en;
	logic [8:0] if_div;
	logic [6:0] gain_raise_level, gain_reduce_level;
	logic [6:0] strength_in, strength_code_bits;
	logic [7:0] gain_settle_count, sequencer_clock_divider, rf_level;
	logic [9:0] post_bw;
	logic [15:0] recovery_oversample_clock;
	logic signed [15:0] corr_plus_level, corr_minus_level, linear_disc;
	logic [15:0] cal_q[$];
	logic [3:0] flag_q[$];
	int corr_t[6] = '{0, 24, 45, 63, 90, 105};
	logic [3:0] pair_t[6] = '{4'he, 4'ha, 4'h9, 4'h8, 4'h4, 4'h0};
	int lvls[3] = '{200, 120, 10};
	int n_mismatch = 0;
	int checks = 0;
	int seed, st, n, blen;
	always #2.5 ref_clk = ~ref_clk;
	rgd_top #(.CAL_CYCLES_P(20)) dut_u (.ref_clk, .reset_n, .clk_en,
		.if_bw_sel, .if_div, .cal_start, .cal_busy, .cal_done, .if_bw_applied,
		.gain_loop_off, .manual_if_gain, .front_amp_mode_bit,
		.front_amp_gain_field, .mixer_linear_bit, .front_amp_mode_out,
		.mixer_linear_out, .gain_raise_level, .gain_reduce_level,
		.gain_settle_count, .sequencer_clock_divider, .offset_clock_divider,
		.offset_clk, .strength_in, .strength_code_bits, .front_amp_gain_flags,
		.if_gain_flags, .demod_sel, .post_bw, .corr_plus_level,
		.corr_minus_level, .linear_disc, .demod_tick,
		.recovery_oversample_clock, .rx_bit, .rx_bit_valid, .correlator_on);
	rgd_rf_model rf_u (.ref_clk, .reset_n, .rf_level, .tx_bit,
		.amp_flags(front_amp_gain_flags), .if_flags(if_gain_flags),
		.strength(strength_in), .plus_lvl(corr_plus_level),
		.minus_lvl(corr_minus_level), .disc(linear_disc), .tick(demod_tick));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic peek(input int k, input logic [3:0] exp);
		flag_q.push_back(exp);
		step(k);
		look = 1'b1;
		step(1);
		look = 1'b0;
	endtask
	function automatic int code(input int s, input int l);
		return (l < corr_t[s]) ? 0 : (l - corr_t[s] > 127 ? 127 : l - corr_t[s]);
	endfunction
	////////////////////////////////////////////////////////////////////////
	// monitors take the oldest note whenever a result shows
	always @(posedge ref_clk) begin
		if (look === 1'b1) begin
			check("gain_flags", 16'({front_amp_gain_flags, if_gain_flags}),
				16'(flag_q.pop_front()));
		end
		if (cal_busy === 1'b1) begin
			blen++;
		end else if (blen != 0) begin
			check("cal_cycles", 16'(blen), cal_q.pop_front());
			blen = 0;
		end
	end
	// watchdog far beyond the expected run of about 12000 cycles
	initial begin
		#200000;
		n_mismatch++;
		summarize();
	end
	initial begin
		seed = 32'h6b7f;
		clk_en = 1'b1;
		{cal_start, gain_loop_off, front_amp_mode_bit, mixer_linear_bit} = 4'h0;
		{if_bw_sel, manual_if_gain, tx_bit, look, blen, st} = 0;
		if_div = 9'h0;
		front_amp_gain_field = FA_GAIN30;
		gain_raise_level = RAISE_LEVEL_RST;
		gain_reduce_level = REDUCE_LEVEL_RST;
		gain_settle_count = SETTLE_COUNT_RST;
		sequencer_clock_divider = 8'h03;
		offset_clock_divider = OFS_DIV4;
		demod_sel = DEMOD_CORREL;
		post_bw = 10'h100;
		recovery_oversample_clock = 16'h3;
		rf_level = 8'h40;
		step(10);
		reset_n = 1'b1;
		peek(20, 4'he);
		// calibrate each bandwidth code; a restart mid-run is ignored
		for (int b = 0; b < 4; b++) begin
			if_bw_sel = b[1:0];
			if_div = 9'($random(seed));
			cal_start = 1'b1;
			cal_q.push_back(16'd20);
			step(1);
			cal_start = 1'b0;
			if_bw_sel = ~b[1:0];
			step(5);
			check("if_bw_applied", 16'(if_bw_applied), 16'(b));
			cal_start = 1'b1;
			step(1);
			cal_start = 1'b0;
			step(20); // host keeps still until calibration ends
			check("cal_done", 16'(cal_done), 16'h1);
		end
		// gain loop from strong, medium, weak, then random levels
		for (int i = 0; i < 9; i++) begin
			n = (i < 3) ? lvls[i] : ($random(seed) & 255) % 232;
			rf_level = 8'(n);
			while (st < 5 && code(st, n) > 70) st++;
			while (st > 0 && code(st, n) < 30) st--;
			peek(600, pair_t[st]);
		end
		// offset clock period per divider code, top code gives 16
		for (int k = 0; k < 4; k++) begin
			offset_clock_divider = 2'(k);
			step(40);
			n = 0;
			while (offset_clk !== 1'b0) step(1);
			while (offset_clk !== 1'b1) step(1);
			for (int j = 0; j < 2; j++) begin
				while (offset_clk === 1'(~j)) begin
					step(1);
					n++;
				end
			end
			check("offset_period", 16'(n), 16'(4 << (k > 2 ? 2 : k)));
		end
		// clock enable low must freeze the divider and the gain pair
		st = {offset_clk, front_amp_gain_flags, if_gain_flags};
		clk_en = 1'b0;
		step(37);
		n = {offset_clk, front_amp_gain_flags, if_gain_flags};
		check("freeze", 16'(n), 16'(st));
		clk_en = 1'b1;
		// only select code 01 turns the correlator on
		for (int k = 0; k < 4; k++) begin
			demod_sel = 2'(k);
			step(1);
			check("correlator_on", 16'(correlator_on), 16'(k == 1));
		end
		demod_sel = DEMOD_CORREL;
		// long runs: a zero threshold keeps deciding them right
		for (int k = 0; k < 2; k++) begin
			tx_bit = ~k[0];
			step(1500);
			n = 0;
			repeat (1280) begin
				step(1);
				n += (rx_bit_valid === 1'b1);
			end
			check("rx_bit", 16'(rx_bit), 16'(tx_bit));
			check("rx_rate", 16'(n >= 9 && n <= 11), 16'h1);
		end
		// host gains with the loop off; a strong level clips the code
		gain_loop_off = 1'b1;
		rf_level = 8'hfa;
		for (int k = 0; k < 12; k++) begin
			front_amp_gain_field = 2'(k / 3);
			manual_if_gain = 2'(k % 3);
			n = $random(seed);
			front_amp_mode_bit = n[0];
			mixer_linear_bit = n[1];
			peek(4, {2'(k / 3), 2'(k % 3)});
			check("amp_mode", 16'(front_amp_mode_out), 16'(n[0]));
			check("mix_linear", 16'(mixer_linear_out), 16'(n[1]));
		end
		check("strength_code", 16'(strength_code_bits), 16'(STRENGTH_MAX));
		summarize();
	end
endmodule // tb
